// File: src/adc_port_cfg.svh
// constants for the dual channel muxed output port
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// converter word and shared bus
`define RESULT_BITS 8
`define RESULT_MSB 7
`define RESULT_ZERO 8'h00
// one fifo word carries both channels of one sampling instant
`define PAIR_BITS 16
`define PAIR_FIFO_DEPTH 32
`define PAIR_LEVEL_BITS 6
// words queued ahead of the first read; with the capture stage this gives five cycles
`define PRIME_LEVEL 6'h04
// pin synchroniser: bit positions and reset value (output enable starts inactive)
`define PIN_COUNT 4
`define PIN_PWRDN 0
`define PIN_SLEEP 1
`define PIN_OE_N 2
`define PIN_FMT 3
`define PIN_RESET 4'h4
// channel indicator levels
`define IND_FIRST 1'b1
`define IND_SECOND 1'b0

`endif

// File: src/adc_port_pkg.sv
// types shared by the muxed output port files
package adc_port_pkg;

	// both channel results of one sampling instant
	typedef struct packed {
		logic [7:0] first_res;
		logic [7:0] second_res;
	} sample_pair_t;

	// stream control: idle (converters off), filling the latency queue, running
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FILL = 2'b01,
		ST_RUN = 2'b10
	} stream_state_t;

endpackage

// File: src/pair_fifo_if.sv
// handshake bundle between the port logic and its sample fifo
`timescale 1ns/1ps
`default_nettype none

interface pair_fifo_if #(
	parameter int WIDTH = 16,
	parameter int LW = 6
) ();
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;
	logic flush;
	logic [LW-1:0] level;

	modport owner (
		output push_valid, push_data, pop_ready, flush,
		input push_ready, pop_valid, pop_data, level
	);
	modport store (
		input push_valid, push_data, pop_ready, flush,
		output push_ready, pop_valid, pop_data, level
	);
endinterface

`default_nettype wire

// File: src/pair_fifo.sv
// synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
`default_nettype none

module pair_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	pair_fifo_if.store port_if
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH + 1);
	localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);
	localparam logic [LW-1:0] EMPTY_LEVEL = '0;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [LW-1:0] level_reg;
	logic push_fire;
	logic pop_fire;

	// honest full and empty straight from the level
	assign port_if.push_ready = (level_reg != FULL_LEVEL);
	assign port_if.pop_valid = (level_reg != EMPTY_LEVEL);
	assign port_if.pop_data = mem[rd_ptr_reg];
	assign port_if.level = level_reg;
	assign push_fire = port_if.push_valid & port_if.push_ready;
	assign pop_fire = port_if.pop_valid & port_if.pop_ready;

	// storage array; no reset needed, reads are gated by the level
	always_ff @(posedge clock_i) begin
		if (push_fire) begin
			mem[wr_ptr_reg] <= port_if.push_data;
		end
	end

	// pointers wrap naturally because the depth is a power of two
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || port_if.flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push_fire) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop_fire) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

	// occupancy
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || port_if.flush) begin
			level_reg <= '0;
		end else if (push_fire && !pop_fire) begin
			level_reg <= level_reg + 1'b1;
		end else if (pop_fire && !push_fire) begin
			level_reg <= level_reg - 1'b1;
		end
	end
endmodule

`default_nettype wire

// File: src/dual_adc_muxed_output_port.sv
// digital output side of a dual 8-bit converter sharing one three-state bus
//
// Summary of operation
// - both channels sampled together on rising edge
// - first channel result out after fifth rising edge
// - second channel result half a period later
// - indicator 1 for first, 0 for second
// - format pin: low offset binary, high two's complement
// - two's complement is offset binary, top bit inverted
// - sleep disables converters, bias stays running
// - power-down pin high enters full power-down
// - power-down with output enable low holds outputs
// - output enable high floats the data bus
// - first updates rising, second falling edge
// - eight-bit bus, bit 7 is the MSB
`timescale 1ns/1ps
`default_nettype none

`include "adc_port_cfg.svh"

module dual_adc_muxed_output_port (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [7:0] first_channel_sample_i,
	input wire logic [7:0] second_channel_sample_i,
	input wire logic format_twos_i,
	input wire logic output_enable_n_i,
	input wire logic sleep_i,
	input wire logic full_powerdown_ctl_i,
	output logic [7:0] shared_result_bus_o,
	output logic shared_result_bus_oe_o,
	output logic channel_indicator_o,
	output logic converters_enabled_o,
	output logic bias_enabled_o
);
	// ==========================================================
	// pin synchronisers
	logic [`PIN_COUNT-1:0] pin_raw;
	logic [`PIN_COUNT-1:0] sync1_reg;
	logic [`PIN_COUNT-1:0] sync2_reg;
	logic [`PIN_COUNT-1:0] sync3_reg;
	logic [`PIN_COUNT-1:0] pin_reg;
	logic [`PIN_COUNT-1:0] pin_agree;
	logic pwrdn;
	logic sleep;
	logic oe_n;
	logic fmt_twos;

	assign pin_raw = {format_twos_i, output_enable_n_i, sleep_i, full_powerdown_ctl_i};

	// three stages; the first is read by the second only
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sync1_reg <= `PIN_RESET;
			sync2_reg <= `PIN_RESET;
			sync3_reg <= `PIN_RESET;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// a pin change counts only once stages two and three agree
	assign pin_agree = ~(sync2_reg ^ sync3_reg);
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pin_reg <= `PIN_RESET;
		end else begin
			pin_reg <= (pin_agree & sync3_reg) | (~pin_agree & pin_reg);
		end
	end

	assign pwrdn = pin_reg[`PIN_PWRDN];
	assign sleep = pin_reg[`PIN_SLEEP];
	assign oe_n = pin_reg[`PIN_OE_N];
	assign fmt_twos = pin_reg[`PIN_FMT];

	// ==========================================================
	// power modes
	// sleep turns the converters off; only full power-down stops the bias
	assign converters_enabled_o = ~sleep & ~pwrdn;
	assign bias_enabled_o = ~pwrdn;

	// ==========================================================
	// sampling
	adc_port_pkg::sample_pair_t cap_reg;
	logic cap_valid_reg;
	pair_fifo_if #(.WIDTH(`PAIR_BITS), .LW(`PAIR_LEVEL_BITS)) q_if ();

	// both channels are caught on the same rising edge; a full queue stalls capture
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			cap_reg <= '0;
			cap_valid_reg <= 1'b0;
		end else if (!cap_valid_reg || q_if.push_ready) begin
			cap_reg.first_res <= first_channel_sample_i;
			cap_reg.second_res <= second_channel_sample_i;
			cap_valid_reg <= converters_enabled_o;
		end
	end

	// ==========================================================
	// latency queue
	adc_port_pkg::stream_state_t state_reg;
	adc_port_pkg::stream_state_t state_next;
	adc_port_pkg::sample_pair_t head;
	logic primed;
	logic pop_fire;

	assign primed = (q_if.level >= `PRIME_LEVEL);
	assign q_if.push_valid = cap_valid_reg & ~sleep;
	assign q_if.push_data = cap_reg;
	assign q_if.flush = (state_reg == adc_port_pkg::ST_IDLE);
	// power-down freezes the read side so the data outputs stay put; the bus enable still follows oe_n
	assign q_if.pop_ready = ~pwrdn & ((state_reg == adc_port_pkg::ST_RUN) ||
		(state_reg == adc_port_pkg::ST_FILL && primed));
	assign pop_fire = q_if.pop_valid & q_if.pop_ready;
	assign head = q_if.pop_data;

	pair_fifo #(
		.WIDTH(`PAIR_BITS),
		.DEPTH(`PAIR_FIFO_DEPTH)
	) u_queue (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.port_if(q_if)
	);

	// stream state: reading starts when four words wait, fixing a five cycle latency
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			adc_port_pkg::ST_IDLE: begin
				if (!sleep) begin
					state_next = adc_port_pkg::ST_FILL;
				end
			end
			adc_port_pkg::ST_FILL: begin
				if (sleep) begin
					state_next = adc_port_pkg::ST_IDLE;
				end else if (pop_fire) begin
					state_next = adc_port_pkg::ST_RUN;
				end
			end
			adc_port_pkg::ST_RUN: begin
				if (sleep) begin
					state_next = adc_port_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = adc_port_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_reg <= adc_port_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// output coding and half-cycle multiplexing
	logic [7:0] fmt_mask;
	logic [7:0] first_out_reg;
	logic [7:0] second_hold_reg;
	logic [7:0] second_out_reg;
	logic rise_tog_reg;
	logic fall_tog_reg;

	// two's complement is offset binary with the MSB flipped
	assign fmt_mask = {fmt_twos, {(`RESULT_MSB){1'b0}}};

	// first channel word and the paired second word move on the rising edge
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			first_out_reg <= `RESULT_ZERO;
			second_hold_reg <= `RESULT_ZERO;
		end else if (pop_fire) begin
			first_out_reg <= head.first_res ^ fmt_mask;
			second_hold_reg <= head.second_res ^ fmt_mask;
		end
	end

	// second channel word lands on the following falling edge
	always_ff @(negedge clock_i) begin
		if (!rst_n_i) begin
			second_out_reg <= `RESULT_ZERO;
		end else if (!pwrdn) begin
			second_out_reg <= second_hold_reg;
		end
	end

	// the indicator is the xor of a rising-edge and a falling-edge toggle, so each
	// edge owns one flop and no signal is driven from both edges
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rise_tog_reg <= 1'b0;
		end else if (!pwrdn) begin
			rise_tog_reg <= ~fall_tog_reg;
		end
	end

	always_ff @(negedge clock_i) begin
		if (!rst_n_i) begin
			fall_tog_reg <= 1'b0;
		end else if (!pwrdn) begin
			fall_tog_reg <= rise_tog_reg;
		end
	end

	assign channel_indicator_o = (rise_tog_reg ^ fall_tog_reg) ? `IND_FIRST : `IND_SECOND;
	assign shared_result_bus_o = channel_indicator_o ? first_out_reg : second_out_reg;
	// drivers are on only while output enable is low; indicator is never floated
	assign shared_result_bus_oe_o = ~oe_n;
endmodule

`default_nettype wire

// File: verif/dual_adc_muxed_output_port_checker.sv
// concurrent checks on the muxed output port pins
`timescale 1ns/1ps
`default_nettype none
module port_checker (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic output_enable_n_i,
	input wire logic sleep_i,
	input wire logic full_powerdown_ctl_i,
	input wire logic [7:0] shared_result_bus_o,
	input wire logic shared_result_bus_oe_o,
	input wire logic channel_indicator_o,
	input wire logic converters_enabled_o,
	input wire logic bias_enabled_o
);
	// ==========
	// pin sequences
	// pins pass a synchroniser, so each is held seven edges before its effect is asked for
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sequence oe_off_s; output_enable_n_i [*7]; endsequence
	sequence oe_on_s; !output_enable_n_i [*7]; endsequence
	sequence nap_s; (sleep_i && !full_powerdown_ctl_i) [*7]; endsequence
	sequence wake_s; (!sleep_i && !full_powerdown_ctl_i) [*7]; endsequence
	sequence down_s; full_powerdown_ctl_i [*7]; endsequence
	// ==========
	// assertions
	bus_float_a: assert property (oe_off_s |-> !shared_result_bus_oe_o) else $error("bus driven");
	bus_drive_a: assert property (oe_on_s |-> shared_result_bus_oe_o) else $error("bus not driven");
	sleep_mode_a: assert property (nap_s |-> !converters_enabled_o && bias_enabled_o) else $error("sleep");
	run_mode_a: assert property (wake_s |-> converters_enabled_o && bias_enabled_o) else $error("awake");
	power_down_a: assert property (down_s |-> !converters_enabled_o && !bias_enabled_o) else $error("power-down");
	first_ind_a: assert property (@(negedge clock_i) bias_enabled_o [*3] |-> channel_indicator_o)
		else $error("indicator low in high half");
	second_ind_a: assert property (bias_enabled_o [*3] |-> !channel_indicator_o) else $error("ind high");
	hold_out_a: assert property (!bias_enabled_o [*3] |-> $stable(shared_result_bus_o) &&
		$stable(channel_indicator_o)) else $error("outputs moved in power-down");
endmodule
`default_nettype wire

// File: verif/capture_model.sv
// receiving logic that splits the shared bus into two streams
`timescale 1ns/1ps
`default_nettype none
module capture_model (
	input wire logic clock_i,
	input wire logic [7:0] bus_i,
	input wire logic oe_i,
	input wire logic ind_i,
	output logic [7:0] first_o,
	output logic [7:0] second_o
);
	// capture once per half period, steered by the indicator level
	always @(posedge clock_i or negedge clock_i) begin
		if (oe_i && ind_i) begin
			first_o <= bus_i;
		end else if (oe_i) begin
			second_o <= bus_i;
		end
	end
endmodule
`default_nettype wire

// File: verif/dual_adc_muxed_output_port_bench.sv
// self-checking bench for the muxed output port
`timescale 1ns/1ps
`default_nettype none
module dual_adc_muxed_output_port_bench;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] sa = 8'h00;
	logic [7:0] sb = 8'h00;
	logic fmt = 1'b0;
	logic oen = 1'b0;
	logic slp = 1'b0;
	logic pwr_off = 1'b0;
	logic [7:0] bus;
	logic oe, ind, conv, bias;
	logic [7:0] first_q, second_q;
	logic [7:0] cor [3] = '{8'hff, 8'h80, 8'h00};
	logic [7:0] qa [$];
	logic [7:0] qb [$];
	int quiet = 0;
	int checks = 0;
	int mismatches = 0;
	int seed;
	// ==========
	// clock and units
	always #20 clock_i = ~clock_i;
	dual_adc_muxed_output_port u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .first_channel_sample_i(sa),
		.second_channel_sample_i(sb), .format_twos_i(fmt), .output_enable_n_i(oen), .sleep_i(slp),
		.full_powerdown_ctl_i(pwr_off), .shared_result_bus_o(bus), .shared_result_bus_oe_o(oe),
		.channel_indicator_o(ind), .converters_enabled_o(conv), .bias_enabled_o(bias));
	capture_model u_rx (.clock_i(clock_i), .bus_i(bus), .oe_i(oe), .ind_i(ind), .first_o(first_q),
		.second_o(second_q));
	// ==========
	// helpers
	function automatic logic [7:0] code(input logic [7:0] v, input logic f);
		return {v[7] ^ f, v[6:0]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// data checked only once pins have been quiet long enough to pass sync and refill
	task automatic run(input int n, input logic f, input logic e, input logic s, input logic p);
		logic [7:0] va, vb;
		for (int i = 0; i < n; i++) begin
			@(posedge clock_i);
			va = (i % 8 < 3) ? cor[i % 8] : 8'($urandom);
			vb = (i % 8 < 3) ? cor[2 - i % 8] : 8'($urandom);
			quiet = ({f, e, s, p} !== {fmt, oen, slp, pwr_off}) ? 0 : quiet + 1;
			fmt <= f;
			oen <= e;
			slp <= s;
			pwr_off <= p;
			sa <= va;
			sb <= vb;
			qa.push_front(va);
			qb.push_front(vb);
			if (qa.size() > 8) begin
				void'(qa.pop_back());
				void'(qb.pop_back());
			end
			#1;
			if (quiet > 15) begin
				check(first_q, code(qa[7], f), "first");
				check(second_q, code(qb[7], f), "second");
			end
		end
	endtask
	task automatic done(input string name);
		$display("test %s done", name);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		seed = $urandom(32'h68765bb2);
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		run(40, 1'b0, 1'b0, 1'b0, 1'b0);
		done("offset binary");
		run(40, 1'b1, 1'b0, 1'b0, 1'b0);
		done("twos complement");
		run(10, 1'b1, 1'b1, 1'b0, 1'b0);
		check({5'h00, oe, conv, bias}, 8'h03, "float");
		done("bus off");
		run(12, 1'b1, 1'b0, 1'b1, 1'b0);
		check({5'h00, oe, conv, bias}, 8'h05, "sleep");
		run(30, 1'b1, 1'b0, 1'b0, 1'b0);
		done("sleep");
		run(12, 1'b0, 1'b0, 1'b0, 1'b1);
		check({5'h00, oe, conv, bias}, 8'h04, "power-down");
		run(8, 1'b0, 1'b0, 1'b1, 1'b1);
		run(8, 1'b0, 1'b0, 1'b1, 1'b0);
		run(30, 1'b0, 1'b0, 1'b0, 1'b0);
		done("power-down");
		report_and_stop();
	end
	// watchdog: the tests need about 206 cycles
	initial begin
		repeat (3000) @(posedge clock_i);
		mismatches++;
		report_and_stop();
	end
endmodule
bind dual_adc_muxed_output_port port_checker u_chk (.clock_i, .rst_n_i, .output_enable_n_i, .sleep_i,
	.full_powerdown_ctl_i, .shared_result_bus_o, .shared_result_bus_oe_o, .channel_indicator_o,
	.converters_enabled_o, .bias_enabled_o);
`default_nettype wire
